// ---- cop_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// - halve select 0 halves pll clock, 1 passes
// - output divider is two to field power
// - source field picks the clock output source
// - source 111 routes the pll path out
// - multiply factor is bit 27 over 21:18
// - low codes add two, 01111 gives sixteen
// - codes 10000 to 11011 add one
// - register at 0x04 resets to 0x00020000
// - codes 11101, 11110, 11111 give 30, 31, 31
// - pll input is half 8 MHz osc or hxtal
module cop_top
   import cop_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic IRC40K_I,
   input wire logic LXTAL_I,
   input wire logic SYSCLK_I,
   input wire logic INTERNAL_8MHZ_OSC_I,
   input wire logic HXTAL_I,
   input wire logic PLL_CLK_I,
   output logic [31:0] RDATA_O,
   output logic [4:0] PLL_MULT_O,
   output logic PLL_SRC_SEL_O,
   output logic PLL_REF_O,
   output logic CLKOUT_O
);

   cop_main_s st_ff;
   cop_main_s nxt_st;

   logic [31:0] cfg_word;
   logic halve_sel;
   logic [2:0] ckout_div;
   logic [2:0] ckout_src;
   logic [4:0] mf_code;
   logic [2:0] pll_div_code;
   logic pll_path;
   logic internal_8mhz_osc_half;
   logic div_out;
   logic wr_hit;
   logic rd_hit;

   // full register image; lower half is not held here and reads zero
   assign cfg_word = {st_ff.cfg_hi, {CFG_LO{1'b0}}};

   // field views of the stored register
   assign halve_sel = cfg_word[HALVE_SEL_BIT];
   assign ckout_div = cfg_word[CKDIV_HI:CKDIV_LO];
   assign ckout_src = cfg_word[CKSRC_HI:CKSRC_LO];
   assign mf_code = {cfg_word[MF_TOP_BIT], cfg_word[MF_LOW_HI:MF_LOW_LO]};

   // address decode for the single mapped word
   assign wr_hit = WR_I && (ADDR_I == CLOCK_CONFIG_ZERO_OFF);
   assign rd_hit = RD_I && (ADDR_I == CLOCK_CONFIG_ZERO_OFF);

   // pll path: halve when the select is low, pass when high
   assign pll_div_code = halve_sel ? DIV_BY1 : DIV_BY2;

   cop_pow2_div u_pll_halve (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .lvl_i(st_ff.sync2[SYN_PLL]),
      .div_code_i(pll_div_code),
      .lvl_o(pll_path)
   );

   // the 8 MHz oscillator is always halved before it may feed the pll
   cop_pow2_div u_internal_8mhz_osc_halve (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .lvl_i(st_ff.sync2[SYN_INTERNAL_8MHZ_OSC]),
      .div_code_i(DIV_BY2),
      .lvl_o(internal_8mhz_osc_half)
   );

   // output divider, power of two from the register field
   cop_pow2_div u_ckout_div (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .lvl_i(st_ff.src_lvl),
      .div_code_i(ckout_div),
      .lvl_o(div_out)
   );

   // multiply factor to multiplier value
   function automatic logic [4:0] mf_decode(input logic [4:0] code);
      logic [4:0] m;
      m = code + MF_ADD_HIGH;
      if (code <= MF_LOW_LAST) begin
         m = code + MF_ADD_LOW;
      end else if (code == MF_DUP16) begin
         m = MULT_16;
      end else if (code == MF_TOP) begin
         m = MULT_31;
      end
      return m;
   endfunction : mf_decode

   // next-state logic for the whole block
   always_comb begin
      nxt_st = st_ff;

      // two-stage synchronisers for every incoming clock level
      nxt_st.sync1 = {PLL_CLK_I, HXTAL_I, INTERNAL_8MHZ_OSC_I, SYSCLK_I, LXTAL_I, IRC40K_I};
      nxt_st.sync2 = st_ff.sync1;

      // register write; reserved bits stay at reset value whatever is sent
      if (wr_hit) begin
         nxt_st.cfg_hi = WDATA_I[31:CFG_LO];
         nxt_st.cfg_hi[RSVD_HI-CFG_LO:RSVD_LO-CFG_LO] =
            CFG_HI_RST[RSVD_HI-CFG_LO:RSVD_LO-CFG_LO];
      end

      // read data stands for exactly one cycle; unmapped reads give zero
      nxt_st.rdata = '0;
      if (rd_hit) begin
         nxt_st.rdata = cfg_word;
      end

      // source mux for the clock output
      case (ckout_src)
         CKSRC_NONE: nxt_st.src_lvl = 1'b0;
         CKSRC_RSVD: nxt_st.src_lvl = 1'b0;
         CKSRC_IRC40K: nxt_st.src_lvl = st_ff.sync2[SYN_IRC40K];
         CKSRC_LXTAL: nxt_st.src_lvl = st_ff.sync2[SYN_LXTAL];
         CKSRC_SYS: nxt_st.src_lvl = st_ff.sync2[SYN_SYS];
         CKSRC_INTERNAL_8MHZ_OSC: nxt_st.src_lvl = st_ff.sync2[SYN_INTERNAL_8MHZ_OSC];
         CKSRC_HXTAL: nxt_st.src_lvl = st_ff.sync2[SYN_HXTAL];
         CKSRC_PLL: nxt_st.src_lvl = pll_path;
         default: nxt_st.src_lvl = 1'b0;
      endcase

      // divided output, retimed so the pin comes from a flop
      nxt_st.clkout = div_out;

      // pll reference select and multiplier
      nxt_st.pll_src_sel = cfg_word[PLL_SRC_BIT];
      nxt_st.pll_ref = cfg_word[PLL_SRC_BIT] ? st_ff.sync2[SYN_HXTAL] : internal_8mhz_osc_half;
      nxt_st.mult = mf_decode(mf_code);
   end

   // single state register; reset loads the documented register value
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_ff <= '0;
         st_ff.cfg_hi <= CFG_HI_RST;
         st_ff.mult <= MF_ADD_LOW;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   assign RDATA_O = st_ff.rdata;
   assign PLL_MULT_O = st_ff.mult;
   assign PLL_SRC_SEL_O = st_ff.pll_src_sel;
   assign PLL_REF_O = st_ff.pll_ref;
   assign CLKOUT_O = st_ff.clkout;

endmodule : cop_top
`default_nettype wire

// ---- cop_pkg.sv ----
package cop_pkg;

   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CLOCK_CONFIG_ZERO_OFF = 8'h04;
   localparam logic [31:0] CLOCK_CONFIG_ZERO_RST = 32'h00020000;

   // upper half of the register is the part held in flops
   localparam int CFG_LO = 16;
   localparam int CFG_W = 16;
   localparam logic [CFG_W-1:0] CFG_HI_RST = CLOCK_CONFIG_ZERO_RST[31:16];

   // field positions, counted in the full 32-bit word
   localparam int HALVE_SEL_BIT = 31;
   localparam int CKDIV_HI = 30;
   localparam int CKDIV_LO = 28;
   localparam int MF_TOP_BIT = 27;
   localparam int CKSRC_HI = 26;
   localparam int CKSRC_LO = 24;
   localparam int RSVD_HI = 23;
   localparam int RSVD_LO = 22;
   localparam int MF_LOW_HI = 21;
   localparam int MF_LOW_LO = 18;
   localparam int DPLL_BIT = 17;
   localparam int PLL_SRC_BIT = 16;

   // clock output source codes
   localparam logic [2:0] CKSRC_NONE = 3'h0;
   localparam logic [2:0] CKSRC_RSVD = 3'h1;
   localparam logic [2:0] CKSRC_IRC40K = 3'h2;
   localparam logic [2:0] CKSRC_LXTAL = 3'h3;
   localparam logic [2:0] CKSRC_SYS = 3'h4;
   localparam logic [2:0] CKSRC_INTERNAL_8MHZ_OSC = 3'h5;
   localparam logic [2:0] CKSRC_HXTAL = 3'h6;
   localparam logic [2:0] CKSRC_PLL = 3'h7;

   // multiply factor decode points
   localparam logic [4:0] MF_LOW_LAST = 5'h0E;
   localparam logic [4:0] MF_DUP16 = 5'h0F;
   localparam logic [4:0] MF_TOP = 5'h1F;
   localparam logic [4:0] MF_ADD_LOW = 5'h02;
   localparam logic [4:0] MF_ADD_HIGH = 5'h01;
   localparam logic [4:0] MULT_16 = 5'h10;
   localparam logic [4:0] MULT_31 = 5'h1F;

   // synchroniser lanes for the incoming clock levels
   localparam int SYN_W = 6;
   localparam int SYN_IRC40K = 0;
   localparam int SYN_LXTAL = 1;
   localparam int SYN_SYS = 2;
   localparam int SYN_INTERNAL_8MHZ_OSC = 3;
   localparam int SYN_HXTAL = 4;
   localparam int SYN_PLL = 5;

   // divider codes: pass through, and halve
   localparam logic [2:0] DIV_BY1 = 3'h0;
   localparam logic [2:0] DIV_BY2 = 3'h1;
   localparam int DIV_CNT_W = 7;

   typedef struct packed {
      logic [CFG_W-1:0] cfg_hi;
      logic [SYN_W-1:0] sync1;
      logic [SYN_W-1:0] sync2;
      logic [31:0] rdata;
      logic [4:0] mult;
      logic src_lvl;
      logic clkout;
      logic pll_ref;
      logic pll_src_sel;
   } cop_main_s;

   typedef struct packed {
      logic prev;
      logic [DIV_CNT_W-1:0] cnt;
      logic out;
   } cop_div_s;

endpackage : cop_pkg

// ---- cop_pow2_div.sv ----
`timescale 1ns/1ps
`default_nettype none

// divides a sampled clock level by two raised to div_code_i
module cop_pow2_div
   import cop_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic lvl_i,
   input wire logic [2:0] div_code_i,
   output logic lvl_o
);

   cop_div_s cur_ff;
   cop_div_s nxt_cur;
   logic rise;

   // count rising edges; output is one counter bit, a clean 50% duty, or the input level itself for code 0
   always_comb begin
      nxt_cur = cur_ff;
      rise = lvl_i & ~cur_ff.prev;
      nxt_cur.prev = lvl_i;
      if (rise) begin
         nxt_cur.cnt = cur_ff.cnt + 7'h01;
      end
      if (div_code_i == DIV_BY1) begin
         nxt_cur.out = lvl_i;
      end else begin
         nxt_cur.out = nxt_cur.cnt[div_code_i - 3'h1];
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign lvl_o = cur_ff.out;

endmodule : cop_pow2_div
`default_nettype wire

// ---- cop_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module cop_chk
   import cop_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic [4:0] PLL_MULT_O,
   input wire logic PLL_SRC_SEL_O
);
   logic w4;
   logic [4:0] mfc;
   logic wrote_ff;
   // taken write and the multiply code it carries
   assign w4 = WR_I && ADDR_I == CLOCK_CONFIG_ZERO_OFF;
   assign mfc = {WDATA_I[27], WDATA_I[21:18]};
   // remembers a write to 0x04, so a read before one can expect the reset word
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wrote_ff <= 1'b0;
      end else if (w4) begin
         wrote_ff <= 1'b1;
      end
   end
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);
   // idle cycle after a write so the code is not overtaken
   AST_RST_READ: assert property (RD_I && ADDR_I == 8'h04 && !wrote_ff |=> RDATA_O == 32'h00020000)
      else $error("bad reset read");
   AST_RSVD_ZERO: assert property ($past(RD_I) |-> RDATA_O[23:22] == 2'b00)
      else $error("reserved bits set");
   AST_MF_LOW: assert property (w4 && mfc < 5'h0F ##1 !w4 |=> PLL_MULT_O == $past(mfc, 2) + 5'h02)
      else $error("low multiplier wrong");
   AST_MF_DUP: assert property (w4 && mfc == 5'h0F ##1 !w4 |=> PLL_MULT_O == 5'h10)
      else $error("code 15 multiplier wrong");
   AST_MF_HIGH: assert property (w4 && mfc[4] && mfc < 5'h1C ##1 !w4 |=> PLL_MULT_O == $past(mfc, 2) + 5'h01)
      else $error("high multiplier wrong");
   AST_MF_C28: assert property (w4 && mfc == 5'h1C ##1 !w4 |=> PLL_MULT_O == 5'h1D)
      else $error("code 28 multiplier wrong");
   AST_MF_TOP: assert property (w4 && mfc > 5'h1C ##1 !w4 |=>
      PLL_MULT_O == ($past(mfc, 2) == 5'h1D ? 5'h1E : 5'h1F))
      else $error("top multiplier wrong");
   AST_SRC_SEL: assert property (w4 ##1 !w4 |=> PLL_SRC_SEL_O == $past(WDATA_I[16], 2))
      else $error("pll source select wrong");
endmodule : cop_chk

bind cop_top cop_chk u_chk (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .PLL_MULT_O(PLL_MULT_O), .PLL_SRC_SEL_O(PLL_SRC_SEL_O));

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import cop_pkg::*;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, ssel, pref, cko, pc, pr;
   logic [7:0] addr = 0, rnd = 8'h2B;
   logic [31:0] wd = 0, rdat, d;
   logic [5:0] ck = 0;
   logic [4:0] mult;
   logic [2:0] dv;
   int n_fail = 0, comparisons = 0, cyc = 0, nc, nr, e, nw, sv;
   // bus clock; test clocks with half periods of 2 to 7 cycles
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 6; i++)
         ck[i] <= 1'((cyc / (i + 2)) % 2);
   end
   cop_top dut (.MCLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
      .RD_I(rd), .IRC40K_I(ck[0]), .LXTAL_I(ck[1]), .SYSCLK_I(ck[2]), .INTERNAL_8MHZ_OSC_I(ck[3]),
      .HXTAL_I(ck[4]), .PLL_CLK_I(ck[5]), .RDATA_O(rdat), .PLL_MULT_O(mult),
      .PLL_SRC_SEL_O(ssel), .PLL_REF_O(pref), .CLKOUT_O(cko));
   function logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // reference multiplier, integers only
   function int mref(int c);
      return c < 15 ? c + 2 : c == 15 ? 16 : c < 29 ? c + 1 : c == 29 ? 30 : 31;
   endfunction : mref
   // tol lets sampled clock counts slip one edge
   task chk(logic [31:0] g, logic [31:0] x, int tol);
      logic near;
      comparisons++;
      // an unknown value must never count as near enough
      near = tol != 0 && g + tol >= x && g <= x + tol;
      if (g !== x && near !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task wr_t(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wd <= v;
      @(posedge clk);
      wr <= 0;
   endtask : wr_t
   task rd_t(logic [7:0] a, logic [31:0] x);
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      @(negedge clk);
      chk(rdat, x, 0);
   endtask : rd_t
   task report_and_stop;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // hang guard, well past the ~16000 cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1;
      wr_t(8'h10, 32'hFFFFFFFF);
      rd_t(8'h04, CLOCK_CONFIG_ZERO_RST);
      rd_t(8'h10, 32'h0);
      // every multiply code, output source left off
      for (int c = 0; c < 32; c++) begin
         rnd = lfsr(rnd);
         d = {rnd[7], 3'h0, c[4], 5'h0, c[3:0], 1'b0, rnd[0], 8'h0, rnd};
         wr_t(8'h04, d);
         repeat (2) @(negedge clk);
         chk(32'(mult), mref(c), 0);
         chk(32'(ssel), 32'(rnd[0]), 0);
         rd_t(8'h04, {d[31:16], 16'h0});
      end
      // every output source with random divider and halving, then divider
      // codes 100 to 111 on the 40 kHz lane over a longer window
      for (int s = 0; s < 12; s++) begin
         rnd = lfsr(rnd);
         sv = s < 8 ? s : 2;
         nw = s < 8 ? 840 : 2048;
         dv = s < 8 ? {1'b0, rnd[1:0]} : 3'(s - 4);
         d = {rnd[7], dv, 1'b0, 3'(sv), 7'h0, rnd[2], 16'h0};
         wr_t(8'h04, d);
         repeat (40) @(negedge clk);
         nc = 0;
         nr = 0;
         pc = cko;
         pr = pref;
         repeat (nw) begin
            @(negedge clk);
            nc += int'(cko && !pc);
            nr += int'(pref && !pr);
            pc = cko;
            pr = pref;
         end
         e = sv < 2 ? 0 : nw / (2 * sv) / (sv == 7 && !rnd[7] ? 2 : 1) >> dv;
         chk(nc, e, 1);
         chk(nr, nw / (rnd[2] ? 12 : 20), 1);
      end
      // reset in mid-run: the word, the multiplier and the pll source select come back
      @(posedge clk);
      rst_b <= 0;
      repeat (3) @(posedge clk);
      rst_b <= 1;
      rd_t(8'h04, CLOCK_CONFIG_ZERO_RST);
      chk(32'(mult), mref(0), 0);
      chk(32'(ssel), 32'h0, 0);
      report_and_stop();
   end
endmodule : testbench

`default_nettype wire
